/* File: nomb_pkg.sv */
package nomb_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFS_OPERATION_CONTROL = 6'h02;
	localparam logic [5:0] OFS_PROTOCOL_MODE_SELECT = 6'h03;
	localparam logic [5:0] OFS_BIT_RATE_SELECT = 6'h04;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RST_OPERATION_CONTROL = 8'h00;
	localparam logic [7:0] RST_PROTOCOL_MODE_SELECT = 8'h08;
	localparam logic [7:0] RST_BIT_RATE_SELECT = 8'h00;

	// ****************************************
	// field layouts
	// ****************************************
	typedef struct packed {
		logic oscRegEnable;
		logic rxEnable;
		logic singleChannel;
		logic manualChannelSel;
		logic txEnable;
		logic wakeupModeEnable;
		logic [1:0] unused;
	} nomb_opctl_s;

	typedef struct packed {
		logic targetRole;
		logic [3:0] opMode;
		logic [1:0] unused;
		logic autoResponseCollisionAvoid;
	} nomb_mode_s;

	typedef struct packed {
		logic [3:0] txRate;
		logic [3:0] rxRate;
	} nomb_rate_s;

	// ****************************************
	// codes
	// ****************************************
	localparam logic [3:0] OM_P2P = 4'h0;
	localparam logic [3:0] OM_TYPE_A = 4'h1;
	localparam logic [3:0] OM_TYPE_B = 4'h2;
	localparam logic [3:0] OM_TYPE_F = 4'h3;
	localparam logic [3:0] OM_TYPE_1 = 4'h4;
	localparam logic [3:0] OM_SUBCARRIER = 4'he;
	localparam logic [3:0] OM_BPSK = 4'hf;
	localparam logic [3:0] OM_TGT_BITRATE_DETECT = 4'h0;
	localparam logic [3:0] OM_TGT_NORMAL = 4'h1;
	localparam logic [3:0] RATE_MAX_CODE = 4'h3;

	typedef enum logic [9:0] {
		PROTO_NONE = 10'h001,
		PROTO_P2P = 10'h002,
		PROTO_TYPE_A = 10'h004,
		PROTO_TYPE_B = 10'h008,
		PROTO_TYPE_F = 10'h010,
		PROTO_TYPE_1 = 10'h020,
		PROTO_SUBCARRIER = 10'h040,
		PROTO_BPSK = 10'h080,
		PROTO_TGT_BITRATE_DETECT = 10'h100,
		PROTO_TGT_NORMAL = 10'h200
	} nomb_proto_e;

endpackage

/* File: nomb_mode_regs.sv */
`timescale 1ns/1ns
`default_nettype none
// How it works
// - bit7 powers oscillator and regulator, ready
// - bit6 enables receive operation
// - bit5 one: single channel via selector
// - bit4 picks automatic or manual channel choice
// - bit3 enables transmit operation
// - field-on sets, p2p transmit-done clears tx
// - bit2 enables wake-up mode
// - operation control resets only at power-up
// - mode and rate reset on set-default too
// - mode bit7 role, bits6-3 operating mode
// - initiator operating mode decode table
// - target decode: p2p detect or normal
// - unsupported mode disables tx and rx
// - mode bit0 starts response collision avoidance
// - rate register: tx high, rx low nibble
// - rate codes 0 to 3 valid only
// - bad rate code disables tx and rx
// - enter-normal command loads rate register
module nomb_mode_regs
	import nomb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	input wire logic cmdSetDefault,
	input wire logic cmdFieldOn,
	input wire logic enterNormalP2pCmd,
	input wire logic [7:0] normalP2pRate,
	input wire logic txFinished,
	input wire logic receiveChannelSelector,
	output logic oscRegEnable,
	output logic rxActive,
	output logic txActive,
	output logic amChannelEnable,
	output logic pmChannelEnable,
	output logic autoChannelSelect,
	output logic wakeupModeEnable,
	output logic targetRole,
	output nomb_proto_e protocolMode,
	output logic autoResponseCollisionAvoid,
	output nomb_rate_s activeRate
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic nomb_proto_e decodeMode(input nomb_mode_s m);
		nomb_proto_e p;
		p = PROTO_NONE;
		if (m.targetRole) begin
			case (m.opMode)
				OM_TGT_BITRATE_DETECT: p = PROTO_TGT_BITRATE_DETECT;
				OM_TGT_NORMAL: p = PROTO_TGT_NORMAL;
				default: p = PROTO_NONE;
			endcase
		end else begin
			case (m.opMode)
				OM_P2P: p = PROTO_P2P;
				OM_TYPE_A: p = PROTO_TYPE_A;
				OM_TYPE_B: p = PROTO_TYPE_B;
				OM_TYPE_F: p = PROTO_TYPE_F;
				OM_TYPE_1: p = PROTO_TYPE_1;
				OM_SUBCARRIER: p = PROTO_SUBCARRIER;
				OM_BPSK: p = PROTO_BPSK;
				default: p = PROTO_NONE;
			endcase
		end
		return p;
	endfunction

	// only codes 0 to 3 are rates
	function automatic logic rateValid(input logic [3:0] code);
		return code <= RATE_MAX_CODE;
	endfunction

	function automatic nomb_opctl_s maskOpctl(input logic [7:0] v);
		nomb_opctl_s r;
		r = nomb_opctl_s'(v);
		r.unused = 2'h0;
		return r;
	endfunction

	function automatic nomb_mode_s maskMode(input logic [7:0] v);
		nomb_mode_s r;
		r = nomb_mode_s'(v);
		r.unused = 2'h0;
		return r;
	endfunction

	// ****************************************
	// register state
	// ****************************************
	nomb_opctl_s opCtl_q;
	nomb_mode_s mode_q;
	nomb_rate_s rate_q;
	logic wrOpCtl;
	logic wrMode;
	logic wrRate;
	nomb_proto_e modeDecoded;
	logic activeP2p;
	logic linkOk;

	assign wrOpCtl = regWrite && (regAddr == OFS_OPERATION_CONTROL);
	assign wrMode = regWrite && (regAddr == OFS_PROTOCOL_MODE_SELECT);
	assign wrRate = regWrite && (regAddr == OFS_BIT_RATE_SELECT);
	assign modeDecoded = decodeMode(mode_q);
	assign activeP2p = (modeDecoded == PROTO_P2P)
		|| (modeDecoded == PROTO_TGT_BITRATE_DETECT)
		|| (modeDecoded == PROTO_TGT_NORMAL);
	assign linkOk = (modeDecoded != PROTO_NONE)
		&& rateValid(rate_q.txRate) && rateValid(rate_q.rxRate);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			opCtl_q <= nomb_opctl_s'(RST_OPERATION_CONTROL);
		end else begin
			if (wrOpCtl) begin
				opCtl_q <= maskOpctl(regWdata);
			end
			if (txFinished && activeP2p) begin
				opCtl_q.txEnable <= 1'b0;
			end
			if (cmdFieldOn) begin
				opCtl_q.txEnable <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_q <= nomb_mode_s'(RST_PROTOCOL_MODE_SELECT);
		end else if (cmdSetDefault) begin
			mode_q <= nomb_mode_s'(RST_PROTOCOL_MODE_SELECT);
		end else if (wrMode) begin
			mode_q <= maskMode(regWdata);
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rate_q <= nomb_rate_s'(RST_BIT_RATE_SELECT);
		end else if (cmdSetDefault) begin
			rate_q <= nomb_rate_s'(RST_BIT_RATE_SELECT);
		end else if (enterNormalP2pCmd) begin
			rate_q <= nomb_rate_s'(normalP2pRate);
		end else if (wrRate) begin
			rate_q <= nomb_rate_s'(regWdata);
		end
	end

	// ****************************************
	// read port
	// ****************************************
	// read data holds until the next read; unmapped reads give zero
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			regRdata <= 8'h00;
		end else if (regRead) begin
			case (regAddr)
				OFS_OPERATION_CONTROL: regRdata <= opCtl_q;
				OFS_PROTOCOL_MODE_SELECT: regRdata <= mode_q;
				OFS_BIT_RATE_SELECT: regRdata <= rate_q;
				default: regRdata <= 8'h00;
			endcase
		end
	end

	// ****************************************
	// control outputs
	// ****************************************
	// registered for clean pins; costs one cycle after the register
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			oscRegEnable <= 1'b0;
			rxActive <= 1'b0;
			txActive <= 1'b0;
			wakeupModeEnable <= 1'b0;
		end else begin
			oscRegEnable <= opCtl_q.oscRegEnable;
			rxActive <= opCtl_q.rxEnable && linkOk;
			txActive <= opCtl_q.txEnable && linkOk;
			wakeupModeEnable <= opCtl_q.wakeupModeEnable;
		end
	end

	// selector low picks the AM channel, high the PM channel
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			amChannelEnable <= 1'b0;
			pmChannelEnable <= 1'b0;
			autoChannelSelect <= 1'b0;
		end else begin
			amChannelEnable <= opCtl_q.rxEnable && linkOk
				&& (!opCtl_q.singleChannel || !receiveChannelSelector);
			pmChannelEnable <= opCtl_q.rxEnable && linkOk
				&& (!opCtl_q.singleChannel || receiveChannelSelector);
			autoChannelSelect <= opCtl_q.rxEnable && linkOk
				&& !opCtl_q.singleChannel && !opCtl_q.manualChannelSel;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			targetRole <= 1'b0;
			protocolMode <= PROTO_TYPE_A;
			autoResponseCollisionAvoid <= 1'b0;
			activeRate <= nomb_rate_s'(RST_BIT_RATE_SELECT);
		end else begin
			targetRole <= mode_q.targetRole;
			protocolMode <= modeDecoded;
			autoResponseCollisionAvoid <=
				mode_q.autoResponseCollisionAvoid;
			// stored codes pass unchanged; linkOk gates bad ones
			activeRate <= rate_q;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_opctl_no_default: assert property (cmdSetDefault && !wrOpCtl
		&& !cmdFieldOn && !txFinished |=> $stable(opCtl_q))
		else $error("set-default changed operation control");
	a_mode_rate_default: assert property (cmdSetDefault |=>
		mode_q == nomb_mode_s'(RST_PROTOCOL_MODE_SELECT)
		&& rate_q == nomb_rate_s'(RST_BIT_RATE_SELECT))
		else $error("set-default did not restore mode or rate");
	a_field_on_tx: assert property (cmdFieldOn |=>
		opCtl_q.txEnable)
		else $error("field-on did not set transmit enable");
	a_p2p_tx_clear: assert property (txFinished && activeP2p
		&& !cmdFieldOn |=> !opCtl_q.txEnable)
		else $error("transmit enable kept after p2p transmit");
	a_rate_load: assert property (enterNormalP2pCmd
		&& !cmdSetDefault |=> rate_q == $past(normalP2pRate))
		else $error("enter-normal did not load rate");
	a_bad_rate_off: assert property (!rateValid(rate_q.txRate)
		|| !rateValid(rate_q.rxRate) |=> !txActive && !rxActive)
		else $error("link active with unsupported rate");
	a_bad_mode_off: assert property (modeDecoded == PROTO_NONE
		|=> !txActive && !rxActive)
		else $error("link active with unsupported mode");
	a_unused_zero: assert property (opCtl_q.unused == 2'h0
		&& mode_q.unused == 2'h0)
		else $error("unused bits not zero");
	a_osc_follow: assert property (wrOpCtl && regWdata[7]
		|-> ##2 oscRegEnable)
		else $error("oscillator not enabled after write");
	a_single_chan: assert property (rxActive
		&& opCtl_q.singleChannel && $stable(opCtl_q)
		|-> !(amChannelEnable && pmChannelEnable))
		else $error("both channels on in single-channel mode");
	// outputs lag their registers one clock, hence the |=> forms
	a_rx_off: assert property (!opCtl_q.rxEnable
		|=> !rxActive)
		else $error("receive active while disabled");
	a_tx_off: assert property (!opCtl_q.txEnable
		|=> !txActive)
		else $error("transmit active while disabled");
	a_osc_off: assert property (wrOpCtl && !regWdata[7]
		|-> ##2 !oscRegEnable)
		else $error("oscillator kept after clearing write");
	a_wakeup_follow: assert property (1'b1 |=>
		wakeupModeEnable == $past(opCtl_q.wakeupModeEnable))
		else $error("wake-up output does not follow its bit");
	a_auto_chan: assert property (opCtl_q.singleChannel
		|| opCtl_q.manualChannelSel |=> !autoChannelSelect)
		else $error("automatic choice outside both-channel mode");
	a_single_am: assert property (rxActive
		&& $past(opCtl_q.singleChannel)
		&& !$past(receiveChannelSelector)
		|-> amChannelEnable && !pmChannelEnable)
		else $error("selector low did not pick the AM channel");
	a_single_pm: assert property (rxActive
		&& $past(opCtl_q.singleChannel)
		&& $past(receiveChannelSelector)
		|-> pmChannelEnable && !amChannelEnable)
		else $error("selector high did not pick the PM channel");
	a_chan_off: assert property (!rxActive
		|-> !amChannelEnable && !pmChannelEnable)
		else $error("channel enabled while receive inactive");
	a_role_follow: assert property (1'b1 |=>
		targetRole == $past(mode_q.targetRole))
		else $error("role output does not follow mode bit 7");
	a_ar_follow: assert property (1'b1 |=>
		autoResponseCollisionAvoid
		== $past(mode_q.autoResponseCollisionAvoid))
		else $error("avoidance output does not follow bit 0");
	a_tgt_decode: assert property (mode_q.targetRole
		&& mode_q.opMode > OM_TGT_NORMAL
		|-> modeDecoded == PROTO_NONE)
		else $error("target decoded an unsupported mode");
	a_init_decode: assert property (!mode_q.targetRole
		&& mode_q.opMode == OM_TYPE_B
		|=> protocolMode == PROTO_TYPE_B)
		else $error("initiator mode 0010 not decoded");
	a_rate_write: assert property (wrRate && !cmdSetDefault
		&& !enterNormalP2pCmd |=> rate_q == $past(regWdata))
		else $error("rate write not stored");
	a_read_unused: assert property (regRead
		&& regAddr == OFS_OPERATION_CONTROL |=> regRdata[1:0] == 2'h0)
		else $error("unused operation control bits read nonzero");

	c_field_on: cover property (cmdFieldOn ##2 txActive);
	c_p2p_clear: cover property (txFinished && activeP2p
		&& opCtl_q.txEnable);
	c_rate_load: cover property (enterNormalP2pCmd ##1 rxActive);
	c_single_chan: cover property (rxActive && !autoChannelSelect
		&& (amChannelEnable != pmChannelEnable));
	c_bad_rate: cover property (opCtl_q.rxEnable
		&& !rateValid(rate_q.txRate) ##1 !rxActive);

endmodule // nomb_mode_regs
`default_nettype wire

/* File: nomb_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// host side of the byte register port
// ****************************************
module nomb_host_model
	import nomb_pkg::*;
(
	input wire logic sys_clk,
	output logic regWrite,
	output logic regRead,
	output logic [ADDR_W-1:0] regAddr,
	output logic [7:0] regWdata
);
	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = '0;
		regWdata = '0;
	end
	// strobe stays up on return so writes can run back to back
	task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		regWrite = 1'b1;
		regRead = 1'b0;
		regAddr = a;
		regWdata = d;
		@(posedge sys_clk);
	endtask
	task rd(input logic [ADDR_W-1:0] a);
		@(negedge sys_clk);
		regRead = 1'b1;
		regWrite = 1'b0;
		regAddr = a;
		@(posedge sys_clk);
	endtask
	// released lines flip so a stale value is never mistaken for data
	task idle();
		@(negedge sys_clk);
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = ~regAddr;
		regWdata = ~regWdata;
	endtask
endmodule // nomb_host_model
`default_nettype wire

/* File: nomb_mode_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module nomb_mode_regs_tb
	import nomb_pkg::*;
;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cmdSetDefault = 1'b0, cmdFieldOn = 1'b0, enterNormalP2pCmd = 1'b0;
	logic txFinished = 1'b0, receiveChannelSelector = 1'b0;
	logic [7:0] normalP2pRate = 8'h00;
	logic regWrite, regRead, rdSeen = 1'b0, oscRegEnable, rxActive, txActive;
	logic [ADDR_W-1:0] regAddr;
	logic [7:0] regWdata, regRdata, r;
	logic amChannelEnable, pmChannelEnable, autoChannelSelect;
	logic wakeupModeEnable, targetRole, autoResponseCollisionAvoid;
	nomb_proto_e protocolMode;
	nomb_rate_s activeRate;
	int miscompares = 0, checks_done = 0, cycles = 0;
	integer seed = 32'h0a9b;
	logic [7:0] expQ[$];
	localparam logic [4:0] MD [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04,
		5'h0e, 5'h0f, 5'h10, 5'h11, 5'h05};
	localparam nomb_proto_e PM [10] = '{PROTO_P2P, PROTO_TYPE_A,
		PROTO_TYPE_B, PROTO_TYPE_F, PROTO_TYPE_1, PROTO_SUBCARRIER, PROTO_BPSK,
		PROTO_TGT_BITRATE_DETECT, PROTO_TGT_NORMAL, PROTO_NONE};

	always #50 sys_clk = ~sys_clk;

	nomb_host_model host (.sys_clk(sys_clk), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata));
	nomb_mode_regs dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
		.regWdata(regWdata), .regRdata(regRdata),
		.cmdSetDefault(cmdSetDefault), .cmdFieldOn(cmdFieldOn),
		.enterNormalP2pCmd(enterNormalP2pCmd), .normalP2pRate(normalP2pRate),
		.txFinished(txFinished),
		.receiveChannelSelector(receiveChannelSelector),
		.oscRegEnable(oscRegEnable), .rxActive(rxActive), .txActive(txActive),
		.amChannelEnable(amChannelEnable), .pmChannelEnable(pmChannelEnable),
		.autoChannelSelect(autoChannelSelect),
		.wakeupModeEnable(wakeupModeEnable), .targetRole(targetRole),
		.protocolMode(protocolMode),
		.autoResponseCollisionAvoid(autoResponseCollisionAvoid),
		.activeRate(activeRate));

	// ****************************************
	// checking and reporting
	// ****************************************
	task end_sim();
		if (miscompares == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	always @(posedge sys_clk) begin
		rdSeen <= regRead;
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	// read data lands one edge after the read, so look half a cycle later
	always @(negedge sys_clk) begin
		if (rdSeen === 1'b1)
			chk(regRdata, expQ.pop_front());
	end
	task rd(input logic [5:0] a, input logic [7:0] e);
		expQ.push_back(e);
		host.rd(a);
	endtask
	task settle();
		host.idle();
		repeat (2) @(negedge sys_clk);
	endtask
	task automatic pulse(ref logic s);
		host.idle();
		s = 1'b1;
		@(negedge sys_clk);
		s = 1'b0;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		repeat (10) @(negedge sys_clk);
		sys_rst = 1'b0;
		receiveChannelSelector = 1'($random(seed));
		rd(OFS_OPERATION_CONTROL, 8'h00);
		rd(OFS_PROTOCOL_MODE_SELECT, 8'h08);
		rd(OFS_BIT_RATE_SELECT, 8'h00);
		rd(6'h3f, 8'h00);
		settle();
		chk(protocolMode, PROTO_TYPE_A);
		chk(oscRegEnable, 1'b0);
		host.wr(OFS_OPERATION_CONTROL, 8'hff);
		host.wr(OFS_PROTOCOL_MODE_SELECT, 8'hff);
		rd(OFS_OPERATION_CONTROL, 8'hfc);
		rd(OFS_PROTOCOL_MODE_SELECT, 8'hf9);
		settle();
		chk({rxActive, txActive}, 2'b00);
		chk({targetRole, autoResponseCollisionAvoid}, 2'b11);
		chk({oscRegEnable, wakeupModeEnable}, 2'b11);
		pulse(cmdSetDefault);
		rd(OFS_OPERATION_CONTROL, 8'hfc);
		rd(OFS_PROTOCOL_MODE_SELECT, 8'h08);
		settle();
		chk({rxActive, txActive, autoChannelSelect}, 3'b110);
		chk(amChannelEnable, !receiveChannelSelector);
		chk(pmChannelEnable, receiveChannelSelector);
		receiveChannelSelector = ~receiveChannelSelector;
		host.wr(OFS_OPERATION_CONTROL, 8'hc0);
		settle();
		chk({amChannelEnable, pmChannelEnable}, 2'b11);
		chk({autoChannelSelect, txActive}, 2'b10);
		host.wr(OFS_OPERATION_CONTROL, 8'hd0);
		settle();
		chk({autoChannelSelect, amChannelEnable}, 2'b01);
		host.wr(OFS_OPERATION_CONTROL, 8'hc8);
		for (int i = 0; i < 10; i++) begin
			host.wr(OFS_PROTOCOL_MODE_SELECT, {MD[i], 3'b000});
			settle();
			chk(protocolMode, PM[i]);
			chk(targetRole, MD[i][4]);
			chk(rxActive, PM[i] != PROTO_NONE);
			chk(txActive, PM[i] != PROTO_NONE);
		end
		host.wr(OFS_PROTOCOL_MODE_SELECT, 8'h08);
		for (int i = 0; i < 12; i++) begin
			r = 8'($random(seed));
			if (i % 2 == 0)
				r = r & 8'h33;
			host.wr(OFS_BIT_RATE_SELECT, r);
			settle();
			chk(activeRate, r);
			chk(txActive, r[7:4] <= RATE_MAX_CODE && r[3:0] <= 4'h3);
			chk(rxActive, r[7:4] <= RATE_MAX_CODE && r[3:0] <= 4'h3);
		end
		normalP2pRate = 8'($random(seed)) & 8'h33;
		pulse(enterNormalP2pCmd);
		rd(OFS_BIT_RATE_SELECT, normalP2pRate);
		host.wr(OFS_PROTOCOL_MODE_SELECT, 8'h00);
		host.wr(OFS_OPERATION_CONTROL, 8'h80);
		pulse(cmdFieldOn);
		rd(OFS_OPERATION_CONTROL, 8'h88);
		pulse(txFinished);
		rd(OFS_OPERATION_CONTROL, 8'h80);
		host.wr(OFS_PROTOCOL_MODE_SELECT, 8'h08);
		pulse(cmdFieldOn);
		pulse(txFinished);
		rd(OFS_OPERATION_CONTROL, 8'h88);
		settle();
		chk(16'(expQ.size()), 16'h0000);
		end_sim();
	end
endmodule // nomb_mode_regs_tb
`default_nettype wire
